// *** verilog/cspm_map.vh ***
`ifndef CSPM_MAP_VH
`define CSPM_MAP_VH

// register byte addresses on the apb bus
`define CSPM_ADDR_W          8
`define CSPM_ADDR_PSR        8'hD0
`define CSPM_ADDR_MOR        8'hE0
`define CSPM_ADDR_PWR        8'h84

// reset values
`define CSPM_PSR_RST         8'h00
`define CSPM_MOR_RST         8'h00
`define CSPM_PWR_RST         8'h00

// program status register fields
`define CSPM_PSR_CY          7
`define CSPM_PSR_AC          6
`define CSPM_PSR_F0          5
`define CSPM_PSR_RS_HI       4
`define CSPM_PSR_RS_LO       3
`define CSPM_PSR_OV          2
`define CSPM_PSR_F1          1
`define CSPM_PSR_PAR         0

// power control register fields
`define CSPM_PWR_IDLE        0
`define CSPM_PWR_STOP        1
`define CSPM_PWR_WDT_EN      2
`define CSPM_PWR_MCD_EN      3
`define CSPM_PWR_MASK        8'h0F

// arithmetic operation codes
`define CSPM_OP_ADD          3'h0
`define CSPM_OP_ADDC         3'h1
`define CSPM_OP_SUBB         3'h2
`define CSPM_OP_MUL          3'h3
`define CSPM_OP_DIV          3'h4
`define CSPM_OP_ARITH        3'h5
`define CSPM_OP_LOAD         3'h6

// power states
`define CSPM_ST_RUN          3'h0
`define CSPM_ST_IDLE         3'h1
`define CSPM_ST_STOP         3'h2

// working register bank geometry
`define CSPM_BANK_SHIFT      3
`define CSPM_MAX_BYTE        9'h0FF

// timing
`define CSPM_CLK_MHZ         100
`define CSPM_MCD_TIMEOUT_US  100
`define CSPM_MCD_CYCLES      (`CSPM_MCD_TIMEOUT_US * `CSPM_CLK_MHZ)
`define CSPM_WDT_CYCLES      65536
`define CSPM_TMO_W           24

`endif

// *** verilog/cspm_alu.v ***
`include "cspm_map.vh"
`default_nettype none

module cspm_alu (
  // operation
  input  wire [2:0] op,
  input  wire [7:0] opa,
  input  wire [7:0] opb,
  input  wire       cin,
  // results
  output reg  [7:0] res,
  output reg  [7:0] bres,
  output reg        cy,
  output reg        ac,
  output reg        ov,
  output reg        ov_upd,
  output reg        cy_upd
);

  reg [8:0]  full;
  reg [4:0]  nib;
  reg [15:0] prod;
  reg        ci;

  // flag derivation per operation
  always @*
  begin
    full   = 9'h000;
    nib    = 5'h00;
    prod   = 16'h0000;
    ci     = 1'b0;
    res    = opa;
    bres   = opb;
    cy     = 1'b0;
    ac     = 1'b0;
    ov     = 1'b0;
    ov_upd = 1'b0;
    cy_upd = 1'b1;
    case (op)
      `CSPM_OP_ADD, `CSPM_OP_ADDC:
      begin
        ci   = (op == `CSPM_OP_ADDC) ? cin : 1'b0;
        full = {1'b0, opa} + {1'b0, opb} + {8'h00, ci};
        nib  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, ci};
        res  = full[7:0];
        cy   = full[8];
        ac   = nib[4];
        ov   = (opa[7] == opb[7]) && (full[7] != opa[7]);
        ov_upd = 1'b1;
      end
      `CSPM_OP_SUBB:
      begin
        full = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
        nib  = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
        res  = full[7:0];
        cy   = full[8];
        ac   = nib[4];
        ov   = (opa[7] != opb[7]) && (full[7] != opa[7]);
        ov_upd = 1'b1;
      end
      `CSPM_OP_MUL:
      begin
        prod = {8'h00, opa} * {8'h00, opb};
        res  = prod[7:0];
        bres = prod[15:8];
        ov   = (prod > {7'h00, `CSPM_MAX_BYTE});
        ov_upd = 1'b1;
      end
      `CSPM_OP_DIV:
      begin
        // a zero divisor leaves both operands untouched
        if (opb != 8'h00)
        begin
          res  = opa / opb;
          bres = opa % opb;
        end
        ov     = (opb == 8'h00);
        ov_upd = 1'b1;
      end
      `CSPM_OP_ARITH:
      begin
        res = opb; // carry flags cleared
      end
      `CSPM_OP_LOAD:
      begin
        res    = opb;
        cy_upd = 1'b0;
      end
      default:
      begin
        cy_upd = 1'b0;
      end
    endcase
  end

endmodule // cspm_alu

`default_nettype wire

// *** verilog/cspm_tmo.v ***
`include "cspm_map.vh"
`default_nettype none

module cspm_tmo #(
  parameter LIMIT = 16
) (
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  // control
  input  wire run,
  input  wire clear,
  // result
  output reg  expire
);

  // full-width limit first, then cut on purpose to the counter width
  localparam [31:0]            LAST_FULL = LIMIT - 1;
  localparam [`CSPM_TMO_W-1:0] LAST      = LAST_FULL[`CSPM_TMO_W-1:0];

  reg [`CSPM_TMO_W-1:0] cnt_q;

  // free count while run, restarts on clear or when stopped
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q  <= {`CSPM_TMO_W{1'b0}};
      expire <= 1'b0;
    end
    else if (clear || !run)
    begin
      cnt_q  <= {`CSPM_TMO_W{1'b0}};
      expire <= 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_q  <= {`CSPM_TMO_W{1'b0}};
      expire <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + {{(`CSPM_TMO_W-1){1'b0}}, 1'b1};
      expire <= 1'b0;
    end
  end

endmodule // cspm_tmo

`default_nettype wire

// *** verilog/cspm_top.v ***
// Decided for this implementation: the APB slave port.
`include "cspm_map.vh"
`default_nettype none

module cspm_top #(
  parameter WDT_CYCLES = `CSPM_WDT_CYCLES,
  parameter MCD_CYCLES = `CSPM_MCD_CYCLES
) (
  // clock and reset
  input  wire                    clk,
  input  wire                    arst_n,
  // apb slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`CSPM_ADDR_W-1:0] paddr,
  input  wire [31:0]             pwdata,
  input  wire [3:0]              pstrb,
  output reg  [31:0]             prdata,
  output wire                    pready,
  output wire                    pslverr,
  // core arithmetic port
  input  wire                    op_valid,
  input  wire [2:0]              op_code,
  input  wire [7:0]              op_operand,
  output reg  [7:0]              op_bresult,
  // core sequencing
  input  wire                    insn_done,
  input  wire                    irq_enabled_pending,
  input  wire                    wdt_kick,
  input  wire [2:0]              wreg_index,
  output wire [7:0]              wreg_addr,
  // power and reset outputs
  output wire                    core_halt,
  output wire                    periph_clk_en,
  output wire                    osc_run,
  output wire                    idle_mode,
  output wire                    stop_mode,
  output reg                     irq_take,
  output reg                     int_reset,
  output reg  [15:0]             restart_pc
);

  localparam [15:0] PC_ZERO = 16'h0000;
  localparam [2:0]  ST_RUN  = `CSPM_ST_RUN;
  localparam [2:0]  ST_IDLE = `CSPM_ST_IDLE;
  localparam [2:0]  ST_STOP = `CSPM_ST_STOP;

  reg  [7:0] psr_q;
  reg  [7:0] mor_q;
  reg  [7:0] pwr_q;
  reg  [2:0] state_q;
  reg  [2:0] state_d;
  wire [7:0] alu_res;
  wire [7:0] alu_bres;
  wire       alu_cy;
  wire       alu_ac;
  wire       alu_ov;
  wire       alu_ov_upd;
  wire       alu_cy_upd;
  wire       wdt_expire;
  wire       mcd_expire;
  wire       soft_rst;
  wire       parity;
  wire       setup;
  wire       access;
  wire       wr;
  wire       mapped;
  wire       wr_psr;
  wire       wr_mor;
  wire       wr_pwr;
  wire       halted;
  wire       alu_go;
  wire [7:0] psr_view;

  // address decode shared by read mux and write strobes
  function is_reg;
    input [`CSPM_ADDR_W-1:0] a;
    input [`CSPM_ADDR_W-1:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction

  // bank base plus register index
  function [7:0] bank_addr;
    input [1:0] bank;
    input [2:0] idx;
    begin
      bank_addr = {3'h0, bank, idx};
    end
  endfunction

  // apb phases; zero wait states, so every access completes at once
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign wr      = access && pwrite && pstrb[0];
  assign mapped  = is_reg(paddr, `CSPM_ADDR_PSR) ||
                   is_reg(paddr, `CSPM_ADDR_MOR) ||
                   is_reg(paddr, `CSPM_ADDR_PWR);
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign wr_psr  = wr && is_reg(paddr, `CSPM_ADDR_PSR);
  assign wr_mor  = wr && is_reg(paddr, `CSPM_ADDR_MOR);
  assign wr_pwr  = wr && is_reg(paddr, `CSPM_ADDR_PWR);

  // parity is recomputed from the accumulator, never stored
  assign parity   = ^mor_q;
  assign psr_view = {psr_q[7:1], parity};

  // working register address from the bank field
  assign wreg_addr = bank_addr(psr_q[`CSPM_PSR_RS_HI:`CSPM_PSR_RS_LO],
                               wreg_index);

  // power state view
  assign idle_mode     = (state_q == ST_IDLE);
  assign stop_mode     = (state_q == ST_STOP);
  assign halted        = idle_mode || stop_mode;
  assign core_halt     = halted;
  assign periph_clk_en = !stop_mode;
  assign osc_run       = !stop_mode;
  assign soft_rst      = wdt_expire || mcd_expire;

  // a halted core issues nothing; guard anyway so state stays frozen
  assign alu_go = op_valid && !halted && !soft_rst;

  cspm_alu u_alu (
    .op     (op_code),
    .opa    (mor_q),
    .opb    (op_operand),
    .cin    (psr_q[`CSPM_PSR_CY]),
    .res    (alu_res),
    .bres   (alu_bres),
    .cy     (alu_cy),
    .ac     (alu_ac),
    .ov     (alu_ov),
    .ov_upd (alu_ov_upd),
    .cy_upd (alu_cy_upd)
  );

  // watchdog runs in run and idle; its count is cleared in stop, where only the monitor runs
  cspm_tmo #(
    .LIMIT (WDT_CYCLES)
  ) u_wdt (
    .clk    (clk),
    .arst_n (arst_n),
    .run    (pwr_q[`CSPM_PWR_WDT_EN] && !stop_mode),
    .clear  (wdt_kick || int_reset),
    .expire (wdt_expire)
  );

  // lost-clock monitor: only stop removes the core clock here
  cspm_tmo #(
    .LIMIT (MCD_CYCLES)
  ) u_mcd (
    .clk    (clk),
    .arst_n (arst_n),
    .run    (pwr_q[`CSPM_PWR_MCD_EN] && stop_mode),
    .clear  (int_reset),
    .expire (mcd_expire)
  );

  // power state transitions; stop wins if both bits are set
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
      begin
        if (insn_done && pwr_q[`CSPM_PWR_STOP])
          state_d = ST_STOP;
        else if (insn_done && pwr_q[`CSPM_PWR_IDLE])
          state_d = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (irq_enabled_pending)
          state_d = ST_RUN;
      end
      ST_STOP:
      begin
        state_d = ST_STOP; // interrupts ignored
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
    if (soft_rst)
      state_d = ST_RUN;
  end

  // state register; the core keeps its pc while halted
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= ST_RUN;
    else
      state_q <= state_d;
  end

  // wake and internal reset pulses
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_take   <= 1'b0;
      int_reset  <= 1'b0;
      restart_pc <= PC_ZERO;
    end
    else
    begin
      // resume is a pulse; pc is untouched so return lands after the setter
      irq_take   <= idle_mode && irq_enabled_pending && !soft_rst;
      int_reset  <= soft_rst;
      restart_pc <= PC_ZERO;
    end
  end

  // power control register; set by software, idle cleared by wake
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pwr_q <= `CSPM_PWR_RST;
    else if (soft_rst)
      pwr_q <= `CSPM_PWR_RST;
    else if (idle_mode && irq_enabled_pending)
      pwr_q[`CSPM_PWR_IDLE] <= 1'b0;
    else if (wr_pwr)
      pwr_q <= pwdata[7:0] & `CSPM_PWR_MASK; // reserved bits dropped
  end

  // status word: flags from the alu, software bits only from the bus
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      psr_q <= `CSPM_PSR_RST;
    else if (soft_rst)
      psr_q <= `CSPM_PSR_RST;
    else if (wr_psr)
      psr_q <= {pwdata[7:1], 1'b0}; // parity bit is read-only
    else if (alu_go)
    begin
      if (alu_cy_upd)
      begin
        psr_q[`CSPM_PSR_CY] <= alu_cy;
        psr_q[`CSPM_PSR_AC] <= alu_ac;
      end
      if (alu_ov_upd)
        psr_q[`CSPM_PSR_OV] <= alu_ov;
    end
  end

  // accumulator; a bus write beats a same-cycle alu result
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mor_q <= `CSPM_MOR_RST;
    else if (soft_rst)
      mor_q <= `CSPM_MOR_RST;
    else if (wr_mor)
      mor_q <= pwdata[7:0];
    else if (alu_go)
      mor_q <= alu_res;
  end

  // second result byte for multiply and divide
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      op_bresult <= 8'h00;
    else if (alu_go)
      op_bresult <= alu_bres;
  end

  // read data captured in the setup phase, steady during access
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
    begin
      if (is_reg(paddr, `CSPM_ADDR_PSR))
        prdata <= {24'h000000, psr_view};
      else if (is_reg(paddr, `CSPM_ADDR_MOR))
        prdata <= {24'h000000, mor_q};
      else if (is_reg(paddr, `CSPM_ADDR_PWR))
        prdata <= {24'h000000, pwr_q};
      else
        prdata <= 32'h00000000;
    end
  end

endmodule // cspm_top

`default_nettype wire

// *** verif/cspm_chk_sva.sv ***
`include "cspm_map.vh"
`default_nettype none

module cspm_chk #(
  parameter WDT_CYCLES = 16,
  parameter MCD_CYCLES = 12
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pslverr,
  // core side
  input wire logic        insn_done,
  input wire logic        irq_enabled_pending,
  input wire logic [2:0]  wreg_index,
  input wire logic [7:0]  wreg_addr,
  // power
  input wire logic        core_halt,
  input wire logic        periph_clk_en,
  input wire logic        osc_run,
  input wire logic        idle_mode,
  input wire logic        stop_mode,
  input wire logic        irq_take,
  input wire logic        int_reset,
  input wire logic [15:0] restart_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // wake steps: pending irq while idle, then run with a service pulse
  sequence s_wake_req;
    idle_mode && irq_enabled_pending;
  endsequence
  sequence s_wake_done;
    !idle_mode && !core_halt && irq_take;
  endsequence

  a_idle_wakes: assert property (s_wake_req |=> s_wake_done)
    else $error("idle did not end on irq");
  a_take_single: assert property (irq_take |=> !irq_take)
    else $error("service pulse too long");
  a_halt_modes: assert property (core_halt == (idle_mode || stop_mode))
    else $error("halt not tied to mode");
  a_clk_gating: assert property (osc_run == !stop_mode && periph_clk_en == !stop_mode)
    else $error("clock gating wrong");
  a_enter_after_insn: assert property ($rose(idle_mode) || $rose(stop_mode) |-> $past(insn_done))
    else $error("mode entered early");
  a_stop_exit_reset: assert property ($fell(stop_mode) |-> int_reset)
    else $error("stop left without reset");
  a_restart_zero: assert property (int_reset |-> restart_pc == 16'h0000 && !core_halt)
    else $error("restart not at zero");
  a_bank_index: assert property (wreg_addr[7:5] == 3'h0 && wreg_addr[2:0] == wreg_index)
    else $error("bank address wrong");
  // only the three mapped words answer without error
  a_unmapped_err: assert property (psel && penable |->
    pslverr == !(paddr inside {`CSPM_ADDR_PSR, `CSPM_ADDR_MOR, `CSPM_ADDR_PWR}))
    else $error("slave error wrong");
endmodule // cspm_chk

bind cspm_top cspm_chk #(.WDT_CYCLES(WDT_CYCLES), .MCD_CYCLES(MCD_CYCLES)) u_chk (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .paddr(paddr),
  .pslverr(pslverr), .insn_done(insn_done), .irq_enabled_pending(irq_enabled_pending),
  .wreg_index(wreg_index), .wreg_addr(wreg_addr), .core_halt(core_halt),
  .periph_clk_en(periph_clk_en), .osc_run(osc_run), .idle_mode(idle_mode),
  .stop_mode(stop_mode), .irq_take(irq_take), .int_reset(int_reset),
  .restart_pc(restart_pc));

`default_nettype wire

// *** verif/core_status_and_power_modes_bench.sv ***
`include "cspm_map.vh"
`default_nettype none

module core_status_and_power_modes_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_PS = `CSPM_ADDR_PSR;
  localparam logic [7:0] A_AC = `CSPM_ADDR_MOR;
  localparam logic [7:0] A_PW = `CSPM_ADDR_PWR;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic        op_valid, insn_done, irq_enabled_pending, wdt_kick;
  logic        core_halt, periph_clk_en, osc_run, idle_mode, stop_mode;
  logic        irq_take, int_reset;
  logic [2:0]  op_code, wreg_index, ws;
  logic [3:0]  pstrb;
  logic [7:0]  paddr, op_operand, op_bresult, wreg_addr;
  logic [15:0] restart_pc;
  logic [31:0] pwdata, prdata;
  int          miscompares, samples_checked;

  // short counts keep watchdog and monitor runs brief
  cspm_top #(.WDT_CYCLES(16), .MCD_CYCLES(12)) i_dut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_operand(op_operand),
    .op_bresult(op_bresult), .insn_done(insn_done), .wdt_kick(wdt_kick),
    .irq_enabled_pending(irq_enabled_pending), .wreg_index(wreg_index),
    .wreg_addr(wreg_addr), .core_halt(core_halt), .periph_clk_en(periph_clk_en),
    .osc_run(osc_run), .idle_mode(idle_mode), .stop_mode(stop_mode),
    .irq_take(irq_take), .int_reset(int_reset), .restart_pc(restart_pc));

  // wait targets picked by index
  assign ws = {int_reset, stop_mode, idle_mode};

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, result is {pslverr, low byte}
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [8:0] r);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      miscompares++;
      end_of_test();
    end
    r = {pslverr, prdata[7:0]};
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [8:0] r;
    apb(1'b1, a, d, r);
  endtask

  task rd(input logic [7:0] a, input logic [8:0] e);
    logic [8:0] r;
    apb(1'b0, a, 8'h00, r);
    chk({23'h0, r}, {23'h0, e});
  endtask

  // bounded wait for a mode flag or int_reset; a hang ends the run
  task wt(input int b, input logic v);
    int n;
    n = 0;
    while (ws[b] !== v && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (ws[b] !== v)
    begin
      miscompares++;
      end_of_test();
    end
  endtask

  task pulse_insn;
    insn_done <= 1'b1;
    @(posedge clk);
    insn_done <= 1'b0;
  endtask

  task t_regs;
    rd(A_PS, 9'h000);
    rd(A_PW, 9'h000);
    rd(8'h10, 9'h100);
    wr(A_PS, 8'hFF);
    rd(A_PS, 9'h0FE);
    wr(A_PW, 8'h08); // reserved bits written as zero
    rd(A_PW, 9'h008);
    wr(A_PW, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(A_PS, 8'(k) << 3 | 8'h22);
      chk({24'h0, wreg_addr}, 32'(k * 8 + 5));
    end
    $display("t_regs end");
  endtask

  // op against a known start; m masks status bits that are not defined
  task t_op(input logic [7:0] s, a, input logic [2:0] c,
            input logic [7:0] b, ea, ep, m, input logic [8:0] eb);
    logic [8:0] r;
    wr(A_PS, s);
    wr(A_AC, a);
    op_valid   <= 1'b1;
    op_code    <= c;
    op_operand <= b;
    @(posedge clk);
    op_valid <= 1'b0;
    apb(1'b0, A_PS, 8'h00, r);
    chk({24'h0, r[7:0] & m}, {24'h0, ep});
    if (m == 8'hFF)
      rd(A_AC, {1'b0, ea});
    if (!eb[8])
      chk({24'h0, op_bresult}, {24'h0, eb[7:0]});
  endtask

  task t_alu;
    t_op(8'h00, 8'h7F, `CSPM_OP_ADD, 8'h01, 8'h80, 8'h45, 8'hFF, 9'h100);
    t_op(8'h04, 8'hFF, `CSPM_OP_ADD, 8'h01, 8'h00, 8'hC0, 8'hFF, 9'h100);
    t_op(8'h80, 8'h01, `CSPM_OP_ADDC, 8'h01, 8'h03, 8'h00, 8'hFF, 9'h100);
    t_op(8'h00, 8'h00, `CSPM_OP_SUBB, 8'h01, 8'hFF, 8'hC0, 8'hFF, 9'h100);
    t_op(8'h00, 8'h80, `CSPM_OP_SUBB, 8'h01, 8'h7F, 8'h45, 8'hFF, 9'h100);
    t_op(8'hC0, 8'h10, `CSPM_OP_MUL, 8'h10, 8'h00, 8'h04, 8'hFF, 9'h001);
    t_op(8'h04, 8'h0F, `CSPM_OP_MUL, 8'h11, 8'hFF, 8'h00, 8'hFF, 9'h000);
    t_op(8'hC4, 8'h07, `CSPM_OP_DIV, 8'h02, 8'h03, 8'h00, 8'hFF, 9'h001);
    t_op(8'hC0, 8'h07, `CSPM_OP_DIV, 8'h00, 8'h00, 8'h04, 8'hC4, 9'h100);
    t_op(8'hC4, 8'h00, `CSPM_OP_ARITH, 8'h01, 8'h01, 8'h05, 8'hFF, 9'h100);
    t_op(8'hC4, 8'h00, `CSPM_OP_LOAD, 8'h03, 8'h03, 8'hC4, 8'hFF, 9'h100);
    $display("t_alu end");
  endtask

  task t_idle;
    wr(A_AC, 8'h5A);
    wr(A_PW, 8'h01);
    pulse_insn();
    wt(0, 1'b1);
    chk({31'h0, periph_clk_en}, 32'h1);
    op_valid   <= 1'b1;
    op_code    <= `CSPM_OP_LOAD;
    op_operand <= 8'h77;
    @(posedge clk);
    op_valid <= 1'b0;
    rd(A_AC, 9'h05A);
    rd(A_PW, 9'h001);
    irq_enabled_pending <= 1'b1;
    wt(0, 1'b0);
    chk({31'h0, irq_take}, 32'h1);
    irq_enabled_pending <= 1'b0;
    rd(A_PW, 9'h000);
    rd(A_AC, 9'h05A);
    $display("t_idle end");
  endtask

  task t_wdt;
    wr(A_PW, 8'h04);
    // a kick every second cycle keeps the count from running out
    repeat (12)
    begin
      wdt_kick <= 1'b1;
      @(posedge clk);
      wdt_kick <= 1'b0;
      @(posedge clk);
      chk({31'h0, int_reset}, 32'h0);
    end
    wr(A_PW, 8'h05);
    pulse_insn();
    wt(0, 1'b1);
    wt(2, 1'b1);
    chk({16'h0, restart_pc}, 32'h0);
    chk({31'h0, idle_mode}, 32'h0);
    rd(A_PW, 9'h000);
    rd(A_AC, 9'h000);
    $display("t_wdt end");
  endtask

  task t_stop;
    wr(A_PW, 8'h0A);
    pulse_insn();
    wt(1, 1'b1);
    chk({30'h0, osc_run, periph_clk_en}, 32'h0);
    irq_enabled_pending <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, stop_mode}, 32'h1);
    irq_enabled_pending <= 1'b0;
    wt(2, 1'b1);
    chk({31'h0, stop_mode}, 32'h0);
    rd(A_PW, 9'h000);
    wr(A_PW, 8'h02);
    pulse_insn();
    wt(1, 1'b1);
    // two low edges, so the async drop of stop is seen while checks are off
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, stop_mode}, 32'h0);
    rd(A_PW, 9'h000);
    $display("t_stop end");
  endtask

  // main sequence
  initial
  begin
    {psel, penable, pwrite, op_valid, insn_done, irq_enabled_pending, wdt_kick} = 7'h00;
    {paddr, op_operand, op_code, pwdata} = 51'h0;
    pstrb = 4'hF;
    wreg_index = 3'h5;
    arst_n = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_alu();
    t_idle();
    t_wdt();
    t_stop();
    end_of_test();
  end
endmodule // core_status_and_power_modes_bench

`default_nettype wire
